/* File: design/cpu_alu_dsp_datapath.sv */
`timescale 1ns/1ns
module cpu_alu_dsp_datapath
	import alu_dsp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              op_valid_i,
	input  wire op_t               op_code_i,
	input  wire logic              byte_mode_i,
	input  wire logic              reg_direct_i,
	input  wire logic [WORD_W-1:0] operand_a_i,
	input  wire logic [WORD_W-1:0] operand_b_i,
	input  wire logic              acc_sel_i,
	input  wire logic              dsp_dual_i,
	input  wire logic [WORD_W-1:0] prefetch_x_i,
	input  wire logic [WORD_W-1:0] prefetch_y_i,
	input  wire logic [WORD_W-1:0] xbus_rdata_i,
	input  wire logic [ADDR_W-1:0] file_addr_i,
	input  wire logic              file_we_i,
	input  wire logic [WORD_W-1:0] file_wdata_i,
	output logic      [WORD_W-1:0] file_rdata_o,
	output logic      [WORD_W-1:0] result_o,
	output logic      [WORD_W-1:0] result_hi_o,
	output logic                   result_we_o,
	output logic                   result_hi_we_o,
	output logic      [1:0]        result_be_o,
	output logic      [WORD_W-1:0] xbus_wdata_o,
	output logic                   xbus_we_o,
	output logic      [WORD_W-1:0] core_status_register_o,
	output logic      [WORD_W-1:0] core_control_register_o
);

	logic [WORD_W-1:0] core_status_r;
	logic [WORD_W-1:0] core_ctrl_r;
	logic [ACC_W-1:0]  acc_r   [NUM_ACC];
	logic [ACC_W-1:0]  acc_nxt [NUM_ACC];
	logic [WORD_W-1:0] alu_res;
	logic [FLAG_W-1:0] alu_flags;
	logic [FLAG_W-1:0] alu_upd;
	logic              is_alu_op;
	logic              is_mcu_mul;
	logic              is_dsp_mul;
	logic              is_acc_op;
	logic [WORD_W-1:0] mul_x;
	logic [WORD_W-1:0] mul_y;
	logic              mul_x_signed;
	logic              mul_y_signed;
	logic              mul_frac;
	logic [ACC_W-1:0]  mul_prod;
	logic [ACC_W-1:0]  dsp_sum;
	logic              file_hit_acc;
	logic              op_go;

	// one operation per cycle from the shared decoder; file writes yield to it
	assign op_go = op_valid_i;

	// classify the operation for the two engines
	always_comb begin
		is_alu_op  = 1'b0;
		is_mcu_mul = 1'b0;
		is_dsp_mul = 1'b0;
		is_acc_op  = 1'b0;
		unique case (op_code_i)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
			OP_SHL, OP_SHR, OP_ASR, OP_SEXT, OP_ZEXT:
				is_alu_op = 1'b1;
			OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_MUL_US:
				is_mcu_mul = 1'b1;
			OP_DSP_MPY, OP_DSP_MPYN, OP_DSP_MAC, OP_DSP_MSC:
				is_dsp_mul = 1'b1;
			OP_ACC_ADD, OP_ACC_LOAD:
				is_acc_op = 1'b1;
			OP_NOP, OP_ACC_STORE: begin
				is_alu_op = 1'b0;
			end
		endcase
	end

	// general arithmetic unit on the full 16-bit path
	general_arith_unit u_gen_arith (
		.op_i    (op_code_i),
		.byte_i  (byte_mode_i),
		.a_i     (operand_a_i),
		.b_i     (operand_b_i),
		.carry_i (core_status_r[SR_C]),
		.res_o   (alu_res),
		.flags_o (alu_flags),
		.upd_o   (alu_upd)
	);

	// multiplier operand steering and mode selection
	always_comb begin
		if (is_dsp_mul) begin
			mul_x        = dsp_dual_i ? prefetch_x_i : xbus_rdata_i;
			mul_y        = prefetch_y_i;
			mul_x_signed = ~core_ctrl_r[CC_SIGNEDNESS];
			mul_y_signed = ~core_ctrl_r[CC_SIGNEDNESS];
			mul_frac     = ~core_ctrl_r[CC_INT_MODE];
		end else begin
			mul_x        = operand_a_i;
			mul_y        = operand_b_i;
			mul_x_signed = (op_code_i == OP_MUL_SS) || (op_code_i == OP_MUL_SU);
			mul_y_signed = (op_code_i == OP_MUL_SS) || (op_code_i == OP_MUL_US);
			mul_frac     = 1'b0;
		end
	end

	// the single multiplier shared by both engines
	shared_multiplier u_mul (
		.x_i        (mul_x),
		.y_i        (mul_y),
		.x_signed_i (mul_x_signed),
		.y_signed_i (mul_y_signed),
		.frac_i     (mul_frac),
		.prod_o     (mul_prod)
	);

	// 40-bit adder/subtractor; fractional product lands with radix right of bit 31
	always_comb begin
		unique case (op_code_i)
			OP_DSP_MPY:  dsp_sum = mul_prod;
			OP_DSP_MPYN: dsp_sum = ACC_RST - mul_prod;
			OP_DSP_MAC:  dsp_sum = acc_r[acc_sel_i] + mul_prod;
			OP_DSP_MSC:  dsp_sum = acc_r[acc_sel_i] - mul_prod;
			OP_ACC_ADD:  dsp_sum = acc_r[acc_sel_i] + acc_r[~acc_sel_i];
			OP_ACC_LOAD: dsp_sum = {{8{xbus_rdata_i[WORD_W-1]}}, xbus_rdata_i, 16'h0000};
			default:     dsp_sum = acc_r[acc_sel_i];
		endcase
	end

	assign file_hit_acc = file_we_i && !op_go;

	// per-accumulator next value: engine result or a single-slice file write
	for (genvar g = 0; g < NUM_ACC; g++) begin : g_acc
		localparam logic [ADDR_W-1:0] BASE = ADDR_W'(g * OFS_ACC_STRIDE);

		always_comb begin
			acc_nxt[g] = acc_r[g];
			if (op_go && (is_dsp_mul || is_acc_op) && (acc_sel_i == 1'(g))) begin
				acc_nxt[g] = dsp_sum;
			end else if (file_hit_acc && (file_addr_i == BASE + OFS_ACC_A_LOW)) begin
				acc_nxt[g][HIGH_LSB-1:LOW_LSB] = file_wdata_i;
			end else if (file_hit_acc && (file_addr_i == BASE + OFS_ACC_A_HIGH)) begin
				acc_nxt[g][GUARD_LSB-1:HIGH_LSB] = file_wdata_i;
			end else if (file_hit_acc && (file_addr_i == BASE + OFS_ACC_A_GUARD)) begin
				acc_nxt[g][ACC_W-1:GUARD_LSB] = file_wdata_i[BYTE_W-1:0];
			end
		end

		// accumulator storage, 40 bits with eight guard bits
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				acc_r[g] <= ACC_RST;
			end else begin
				acc_r[g] <= acc_nxt[g];
			end
		end
	end

	// core status flags: operation updates win over a file write
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_status_r <= STATUS_RST;
		end else if (op_go && is_alu_op) begin
			if (alu_upd[FL_C])  core_status_r[SR_C]  <= alu_flags[FL_C];
			if (alu_upd[FL_Z])  core_status_r[SR_Z]  <= alu_flags[FL_Z];
			if (alu_upd[FL_OV]) core_status_r[SR_OV] <= alu_flags[FL_OV];
			if (alu_upd[FL_N])  core_status_r[SR_N]  <= alu_flags[FL_N];
			if (alu_upd[FL_DC]) core_status_r[SR_DC] <= alu_flags[FL_DC];
		end else if (file_hit_acc && (file_addr_i == OFS_CORE_STATUS)) begin
			core_status_r[SR_C]  <= file_wdata_i[SR_C];
			core_status_r[SR_Z]  <= file_wdata_i[SR_Z];
			core_status_r[SR_OV] <= file_wdata_i[SR_OV];
			core_status_r[SR_N]  <= file_wdata_i[SR_N];
			core_status_r[SR_DC] <= file_wdata_i[SR_DC];
		end
	end

	// core control: only the multiply mode and signedness bits are held here
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_ctrl_r <= CTRL_RST;
		end else if (file_hit_acc && (file_addr_i == OFS_CORE_CTRL)) begin
			core_ctrl_r[CC_INT_MODE]   <= file_wdata_i[CC_INT_MODE];
			core_ctrl_r[CC_SIGNEDNESS] <= file_wdata_i[CC_SIGNEDNESS];
		end
	end

	// working-register result port
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_o       <= '0;
			result_hi_o    <= '0;
			result_we_o    <= 1'b0;
			result_hi_we_o <= 1'b0;
			result_be_o    <= BE_WORD;
		end else begin
			result_we_o    <= op_go && (is_alu_op || is_mcu_mul);
			result_hi_we_o <= op_go && is_mcu_mul;
			result_hi_o    <= mul_prod[PROD_W-1:WORD_W];
			if (is_mcu_mul) begin
				result_o    <= mul_prod[WORD_W-1:0];
				result_be_o <= BE_WORD;
			end else begin
				result_o    <= alu_res;
				result_be_o <= (byte_mode_i && (op_code_i != OP_SEXT) &&
					(op_code_i != OP_ZEXT)) ? BE_LOW_ONLY : BE_WORD;
			end
		end
	end

	// X data bus write: accumulator store or a non-register-direct ALU result
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			xbus_wdata_o <= '0;
			xbus_we_o    <= 1'b0;
		end else begin
			if (op_code_i == OP_ACC_STORE) begin
				xbus_wdata_o <= acc_r[acc_sel_i][GUARD_LSB-1:HIGH_LSB];
			end else if (is_mcu_mul) begin
				xbus_wdata_o <= mul_prod[WORD_W-1:0];
			end else begin
				xbus_wdata_o <= alu_res;
			end
			xbus_we_o <= op_go && ((op_code_i == OP_ACC_STORE) ||
				(is_alu_op && !reg_direct_i));
		end
	end

	// file-register read port, one cycle after the address
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			file_rdata_o <= '0;
		end else begin
			unique case (file_addr_i)
				OFS_ACC_A_LOW:   file_rdata_o <= acc_r[0][HIGH_LSB-1:LOW_LSB];
				OFS_ACC_A_HIGH:  file_rdata_o <= acc_r[0][GUARD_LSB-1:HIGH_LSB];
				OFS_ACC_A_GUARD: file_rdata_o <= {8'h00, acc_r[0][ACC_W-1:GUARD_LSB]};
				OFS_ACC_B_LOW:   file_rdata_o <= acc_r[1][HIGH_LSB-1:LOW_LSB];
				OFS_ACC_B_HIGH:  file_rdata_o <= acc_r[1][GUARD_LSB-1:HIGH_LSB];
				OFS_ACC_B_GUARD: file_rdata_o <= {8'h00, acc_r[1][ACC_W-1:GUARD_LSB]};
				OFS_CORE_STATUS: file_rdata_o <= core_status_r;
				OFS_CORE_CTRL:   file_rdata_o <= core_ctrl_r;
				default:         file_rdata_o <= '0;
			endcase
		end
	end

	// status and control mirrors
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_status_register_o  <= STATUS_RST;
			core_control_register_o <= CTRL_RST;
		end else begin
			core_status_register_o  <= core_status_r;
			core_control_register_o <= core_ctrl_r;
		end
	end

endmodule : cpu_alu_dsp_datapath

/* File: design/alu_dsp_pkg.sv */
package alu_dsp_pkg;

	// datapath widths
	localparam int WORD_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int MUL_W    = 17;
	localparam int PROD_W   = 32;
	localparam int ACC_W    = 40;
	localparam int ADDR_W   = 4;
	localparam int NUM_ACC  = 2;
	localparam int FLAG_W   = 5;

	// memory-mapped register offsets (word index on the file-register port)
	localparam logic [ADDR_W-1:0] OFS_ACC_A_LOW   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_ACC_A_HIGH  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_ACC_A_GUARD = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_ACC_B_LOW   = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_ACC_B_HIGH  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_ACC_B_GUARD = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_CORE_STATUS = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_CORE_CTRL   = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_ACC_STRIDE  = 4'h3;

	// accumulator slice positions
	localparam int LOW_LSB   = 0;
	localparam int HIGH_LSB  = 16;
	localparam int GUARD_LSB = 32;

	// core status register bit positions
	localparam int SR_C  = 0;
	localparam int SR_Z  = 1;
	localparam int SR_OV = 2;
	localparam int SR_N  = 3;
	localparam int SR_DC = 8;

	// index of each flag in the general unit flag vector {dc,n,ov,z,c}
	localparam int FL_C  = 0;
	localparam int FL_Z  = 1;
	localparam int FL_OV = 2;
	localparam int FL_N  = 3;
	localparam int FL_DC = 4;

	// core control register bit positions
	localparam int CC_INT_MODE   = 0;
	localparam int CC_SIGNEDNESS = 12;

	// reset values
	localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;
	localparam logic [WORD_W-1:0] CTRL_RST   = 16'h0000;
	localparam logic [ACC_W-1:0]  ACC_RST    = 40'h00_0000_0000;

	// byte enables of a working-register write
	localparam logic [1:0] BE_LOW_ONLY = 2'h1;
	localparam logic [1:0] BE_WORD     = 2'h3;

	// operations issued by the instruction decoder
	typedef enum logic [4:0] {
		OP_NOP,
		OP_ADD,
		OP_ADDC,
		OP_SUB,
		OP_SUBB,
		OP_AND,
		OP_IOR,
		OP_XOR,
		OP_SHL,
		OP_SHR,
		OP_ASR,
		OP_SEXT,
		OP_ZEXT,
		OP_MUL_UU,
		OP_MUL_SS,
		OP_MUL_SU,
		OP_MUL_US,
		OP_DSP_MPY,
		OP_DSP_MPYN,
		OP_DSP_MAC,
		OP_DSP_MSC,
		OP_ACC_ADD,
		OP_ACC_LOAD,
		OP_ACC_STORE
	} op_t;

endpackage : alu_dsp_pkg

/* File: design/general_arith_unit.sv */
`timescale 1ns/1ns
module general_arith_unit
	import alu_dsp_pkg::*;
(
	input  wire op_t               op_i,
	input  wire logic              byte_i,
	input  wire logic [WORD_W-1:0] a_i,
	input  wire logic [WORD_W-1:0] b_i,
	input  wire logic              carry_i,
	output logic      [WORD_W-1:0] res_o,
	output logic      [FLAG_W-1:0] flags_o,
	output logic      [FLAG_W-1:0] upd_o
);

	logic              is_sub;
	logic              cin;
	logic [WORD_W-1:0] bb;
	logic [WORD_W:0]   sum_w;
	logic [BYTE_W:0]   sum_b;
	logic [8:0]        dc_w;
	logic [4:0]        dc_b;
	logic              msb_a;
	logic              msb_b;
	logic              msb_r;

	// adder front end; subtraction adds the inverted operand, carry acts as not-borrow
	always_comb begin
		is_sub = (op_i == OP_SUB) || (op_i == OP_SUBB);
		bb     = is_sub ? ~b_i : b_i;
		unique case (op_i)
			OP_ADDC, OP_SUBB: cin = carry_i;
			OP_SUB:           cin = 1'b1;
			default:          cin = 1'b0;
		endcase
		sum_w = {1'b0, a_i} + {1'b0, bb} + {16'h0000, cin};
		sum_b = {1'b0, a_i[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
		dc_w  = {1'b0, a_i[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
		dc_b  = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
	end

	// result, flags and which flags the operation touches
	always_comb begin
		res_o   = '0;
		flags_o = '0;
		upd_o   = '0;
		unique case (op_i)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
				res_o          = sum_w[WORD_W-1:0];
				flags_o[FL_C]  = byte_i ? sum_b[BYTE_W] : sum_w[WORD_W];
				flags_o[FL_DC] = byte_i ? dc_b[4] : dc_w[8];
				upd_o          = 5'h1f;
			end
			OP_AND: begin
				res_o = a_i & b_i;
				upd_o = 5'h0a;
			end
			OP_IOR: begin
				res_o = a_i | b_i;
				upd_o = 5'h0a;
			end
			OP_XOR: begin
				res_o = a_i ^ b_i;
				upd_o = 5'h0a;
			end
			OP_SHL: begin
				res_o         = {a_i[WORD_W-2:0], 1'b0};
				flags_o[FL_C] = byte_i ? a_i[7] : a_i[15];
				upd_o         = 5'h0b;
			end
			OP_SHR: begin
				res_o         = byte_i ? {8'h00, 1'b0, a_i[7:1]} : {1'b0, a_i[15:1]};
				flags_o[FL_C] = a_i[0];
				upd_o         = 5'h0b;
			end
			OP_ASR: begin
				res_o         = byte_i ? {8'h00, a_i[7], a_i[7:1]} : {a_i[15], a_i[15:1]};
				flags_o[FL_C] = a_i[0];
				upd_o         = 5'h0b;
			end
			OP_SEXT: begin
				res_o = {{8{a_i[7]}}, a_i[7:0]};
				upd_o = 5'h0b;
			end
			OP_ZEXT: begin
				res_o = {8'h00, a_i[7:0]};
				upd_o = 5'h0b;
			end
			default: begin
				res_o = '0;
			end
		endcase
		// sign and zero come from the low byte in byte mode, except for SEXT and ZEXT, which use bit 15 and the whole word
		msb_a          = byte_i ? a_i[7] : a_i[15];
		msb_b          = byte_i ? bb[7] : bb[15];
		msb_r          = (byte_i && (op_i != OP_SEXT) && (op_i != OP_ZEXT)) ? res_o[7] : res_o[15];
		flags_o[FL_N]  = msb_r;
		flags_o[FL_OV] = (msb_a == msb_b) && (msb_r != msb_a);
		flags_o[FL_Z]  = (byte_i && (op_i != OP_SEXT) && (op_i != OP_ZEXT)) ?
			(res_o[7:0] == 8'h00) : (res_o == 16'h0000);
	end

endmodule : general_arith_unit

/* File: design/shared_multiplier.sv */
`timescale 1ns/1ns
module shared_multiplier
	import alu_dsp_pkg::*;
(
	input  wire logic [WORD_W-1:0] x_i,
	input  wire logic [WORD_W-1:0] y_i,
	input  wire logic              x_signed_i,
	input  wire logic              y_signed_i,
	input  wire logic              frac_i,
	output logic      [ACC_W-1:0]  prod_o
);

	logic [MUL_W-1:0]   x17;
	logic [MUL_W-1:0]   y17;
	logic [2*MUL_W-1:0] p34;
	logic [ACC_W-1:0]   p40;

	// widen to 17 bits so mixed and unsigned products come out right
	always_comb begin
		x17    = {x_signed_i & x_i[WORD_W-1], x_i};
		y17    = {y_signed_i & y_i[WORD_W-1], y_i};
		p34    = 34'($signed(x17) * $signed(y17));
		p40    = {{(ACC_W-2*MUL_W){p34[2*MUL_W-1]}}, p34};
		prod_o = frac_i ? {p40[ACC_W-2:0], 1'b0} : p40;
	end

endmodule : shared_multiplier

/* File: verif/cpu_alu_dsp_datapath_assertions.sv */
`timescale 1ns/1ns
module alu_datapath_checker
	import alu_dsp_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              reset_n_i,
	input wire logic              op_valid_i,
	input wire op_t               op_code_i,
	input wire logic              byte_mode_i,
	input wire logic [WORD_W-1:0] operand_a_i,
	input wire logic [WORD_W-1:0] operand_b_i,
	input wire logic [WORD_W-1:0] result_o,
	input wire logic [WORD_W-1:0] result_hi_o,
	input wire logic              result_hi_we_o,
	input wire logic [1:0]        result_be_o,
	input wire logic              xbus_we_o,
	input wire logic [WORD_W-1:0] core_status_register_o,
	input wire logic [WORD_W-1:0] core_control_register_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// word add issue, then its result
	sequence add_word_s;
		op_valid_i && op_code_i == OP_ADD && !byte_mode_i;
	endsequence
	sequence zero_sum_s;
		add_word_s ##1 result_o == 16'h0000;
	endsequence
	sequence byte_op_s;
		op_valid_i && byte_mode_i && op_code_i inside {OP_ADD, OP_SUB, OP_AND, OP_XOR};
	endsequence
	sequence borrow_s;
		op_valid_i && op_code_i == OP_SUB && !byte_mode_i && operand_a_i < operand_b_i;
	endsequence
	AST_ADD_SUM: assert property (add_word_s |=>
		result_o == 16'($past(operand_a_i) + $past(operand_b_i)))
		else $error("word add result wrong");
	AST_ZERO_FLAG: assert property (zero_sum_s |-> ##1 core_status_register_o[SR_Z])
		else $error("zero flag missing");
	AST_BORROW: assert property (borrow_s |-> ##2 !core_status_register_o[SR_C])
		else $error("borrow not shown on carry");
	AST_BYTE_BE: assert property (byte_op_s |=> result_be_o == BE_LOW_ONLY)
		else $error("byte op wrote more than low byte");
	AST_BYTE_SUM: assert property (byte_op_s ##0 (op_code_i == OP_ADD) |=>
		result_o[7:0] == 8'($past(operand_a_i[7:0]) + $past(operand_b_i[7:0])))
		else $error("byte add low byte wrong");
	AST_SEXT: assert property (op_valid_i && op_code_i == OP_SEXT |=>
		result_o == {{8{$past(operand_a_i[7])}}, $past(operand_a_i[7:0])})
		else $error("sign extend wrong");
	AST_ZEXT: assert property (op_valid_i && op_code_i == OP_ZEXT |=>
		result_o == {8'h00, $past(operand_a_i[7:0])})
		else $error("zero extend wrong");
	AST_MUL_UU: assert property (op_valid_i && op_code_i == OP_MUL_UU |=>
		result_hi_we_o && {result_hi_o, result_o} ==
		{16'h0000, $past(operand_a_i)} * {16'h0000, $past(operand_b_i)})
		else $error("unsigned multiply wrong");
	AST_STORE: assert property (op_valid_i && op_code_i == OP_ACC_STORE |=> xbus_we_o)
		else $error("store did not write x bus");
	AST_MODE_RESET: assert property ($rose(reset_n_i) |->
		!core_control_register_o[CC_INT_MODE])
		else $error("mode not fractional after reset");
endmodule : alu_datapath_checker
bind cpu_alu_dsp_datapath alu_datapath_checker i_alu_datapath_checker (.*);

/* File: verif/xbus_data_model.sv */
`timescale 1ns/1ns
module xbus_data_model
	import alu_dsp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              rd_en_i,
	input  wire logic [WORD_W-1:0] load_word_i,
	input  wire logic              xbus_we_i,
	input  wire logic [WORD_W-1:0] xbus_wdata_i,
	output logic      [WORD_W-1:0] xbus_rdata_o,
	output logic      [WORD_W-1:0] mem_word_o
);
	// read data only during a read, otherwise a stale inverted word
	assign xbus_rdata_o = rd_en_i ? load_word_i : ~mem_word_o;
	// memory word written by the engine over the x bus
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_word_o <= 16'h0000;
		end else if (xbus_we_i) begin
			mem_word_o <= xbus_wdata_i;
		end
	end
endmodule : xbus_data_model

/* File: verif/tb_cpu_alu_dsp_datapath.sv */
`timescale 1ns/1ns
module tb_cpu_alu_dsp_datapath;
	import alu_dsp_pkg::*;
	typedef struct packed {
		op_t         op;
		logic        bm;
		logic [15:0] a, b, res, hi, st;
	} row_t;
	localparam row_t ROWS [19] = '{
		'{OP_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 16'h0000, 16'h010c},
		'{OP_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0000, 16'h0000, 16'h0103},
		'{OP_SUB, 1'b0, 16'h0000, 16'h0001, 16'hffff, 16'h0000, 16'h0008},
		'{OP_SUB, 1'b0, 16'h0005, 16'h0003, 16'h0002, 16'h0000, 16'h0101},
		'{OP_ADDC, 1'b0, 16'h0001, 16'h0001, 16'h0003, 16'h0000, 16'h0000},
		'{OP_SUBB, 1'b0, 16'h0005, 16'h0003, 16'h0001, 16'h0000, 16'h0101},
		'{OP_ADD, 1'b1, 16'h12ff, 16'h0001, 16'h0000, 16'h0000, 16'h0103},
		'{OP_AND, 1'b0, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'h0000, 16'h0000},
		'{OP_IOR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 16'h0000, 16'h0008},
		'{OP_XOR, 1'b0, 16'haaaa, 16'haaaa, 16'h0000, 16'h0000, 16'h0002},
		'{OP_SHL, 1'b0, 16'h4001, 16'h0000, 16'h8002, 16'h0000, 16'h0008},
		'{OP_SHR, 1'b0, 16'h8001, 16'h0000, 16'h4000, 16'h0000, 16'h0000},
		'{OP_ASR, 1'b0, 16'h8001, 16'h0000, 16'hc000, 16'h0000, 16'h0008},
		'{OP_SEXT, 1'b0, 16'h1280, 16'h0000, 16'hff80, 16'h0000, 16'h0000},
		'{OP_ZEXT, 1'b0, 16'habcd, 16'h0000, 16'h00cd, 16'h0000, 16'h0000},
		'{OP_MUL_SS, 1'b0, 16'hffff, 16'h0002, 16'hfffe, 16'hffff, 16'h0000},
		'{OP_MUL_UU, 1'b0, 16'hffff, 16'h0002, 16'hfffe, 16'h0001, 16'h0000},
		'{OP_MUL_SU, 1'b0, 16'hffff, 16'h0002, 16'hfffe, 16'hffff, 16'h0000},
		'{OP_MUL_US, 1'b0, 16'hffff, 16'h0002, 16'hfffe, 16'h0001, 16'h0000}
	};
	logic              clk_i = 1'b0;
	logic              reset_n_i = 1'b0;
	logic              op_valid_i = 1'b0;
	op_t               op_code_i = OP_NOP;
	logic              byte_mode_i = 1'b0, reg_direct_i = 1'b1, acc_sel_i = 1'b0;
	logic              dsp_dual_i = 1'b1, file_we_i = 1'b0, result_we_o, result_hi_we_o;
	logic              xbus_we_o;
	logic [1:0]        result_be_o;
	logic [ADDR_W-1:0] file_addr_i = 4'h0;
	logic [15:0]       operand_a_i = 16'h0000, operand_b_i = 16'h0000, file_wdata_i = 16'h0000;
	logic [15:0]       prefetch_x_i = 16'h0000, prefetch_y_i = 16'h0000, load_word = 16'h0000;
	logic [15:0]       xbus_rdata_i, file_rdata_o, result_o, result_hi_o, xbus_wdata_o;
	logic [15:0]       core_status_register_o, core_control_register_o, mem_word, m;
	int                fail_count = 0, samples_checked = 0;

	always #25 clk_i = ~clk_i;
	cpu_alu_dsp_datapath i_cpu_alu_dsp_datapath (.*);
	xbus_data_model i_xbus_data_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.rd_en_i(op_valid_i), .load_word_i(load_word), .xbus_we_i(xbus_we_o),
		.xbus_wdata_i(xbus_wdata_o), .xbus_rdata_o(xbus_rdata_i), .mem_word_o(mem_word));

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// issue one operation for one cycle, return just after it lands
	task automatic run_op(input op_t op, input logic bm, input logic [15:0] a, input logic [15:0] b);
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_code_i <= op;
		byte_mode_i <= bm;
		operand_a_i <= a;
		operand_b_i <= b;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
	endtask : run_op
	task automatic dsp(input op_t op, input logic sel, input logic [15:0] x, input logic [15:0] y);
		@(posedge clk_i);
		acc_sel_i <= sel;
		prefetch_x_i <= x;
		prefetch_y_i <= y;
		run_op(op, 1'b0, 16'h0000, 16'h0000);
	endtask : dsp
	task automatic wr(input logic [3:0] ad, input logic [15:0] d, input logic v);
		@(posedge clk_i);
		file_we_i <= 1'b1;
		file_addr_i <= ad;
		file_wdata_i <= d;
		op_valid_i <= v;
		op_code_i <= OP_NOP;
		@(posedge clk_i);
		file_we_i <= 1'b0;
		op_valid_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input logic [15:0] e, input string n);
		@(posedge clk_i);
		file_addr_i <= ad;
		@(posedge clk_i);
		#1;
		chk(n, e, file_rdata_o);
	endtask : rd
	function automatic logic [15:0] flag_mask(input op_t op);
		if (op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB}) return 16'h010f;
		if (op inside {OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_SHR, OP_ASR}) return 16'h000a;
		return 16'h0000;
	endfunction : flag_mask
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// watchdog sized well above the roughly 140 cycles of the sequence
	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		end_sim;
	end
	// main sequence: reset, table of general and multiply ops, then engine and slice cases
	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(OFS_CORE_CTRL, CTRL_RST, "control_at_reset");
		chk("status_at_reset", STATUS_RST, core_status_register_o);
		foreach (ROWS[i]) begin
			run_op(ROWS[i].op, ROWS[i].bm, ROWS[i].a, ROWS[i].b);
			m = ROWS[i].bm ? 16'h00ff : 16'hffff;
			chk("result", ROWS[i].res & m, result_o & m);
			chk("result_we", 16'h0001, {15'h0000, result_we_o});
			chk("byte_enables", ROWS[i].bm ? 16'h0001 : 16'h0003, {14'h0000, result_be_o});
			if (ROWS[i].op inside {OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_MUL_US})
				chk("result_high", ROWS[i].hi, result_hi_o);
			@(posedge clk_i);
			#1;
			chk("status", ROWS[i].st, core_status_register_o & flag_mask(ROWS[i].op));
		end
		dsp(OP_DSP_MPY, 1'b0, 16'h4000, 16'h4000);
		rd(OFS_ACC_A_HIGH, 16'h2000, "frac_high");
		rd(OFS_ACC_A_LOW, 16'h0000, "frac_low");
		wr(OFS_CORE_CTRL, 16'h0001, 1'b0);
		dsp(OP_DSP_MPY, 1'b0, 16'hffff, 16'h0002);
		rd(OFS_ACC_A_GUARD, 16'h00ff, "int_guard");
		rd(OFS_ACC_A_LOW, 16'hfffe, "int_low");
		wr(OFS_CORE_CTRL, 16'h1001, 1'b0);
		dsp(OP_DSP_MPY, 1'b1, 16'hffff, 16'h0002);
		dsp(OP_DSP_MAC, 1'b1, 16'hffff, 16'h0002);
		rd(OFS_ACC_B_HIGH, 16'h0003, "mac_high");
		dsp(OP_DSP_MSC, 1'b1, 16'hffff, 16'h0002);
		dsp(OP_DSP_MPYN, 1'b0, 16'hffff, 16'h0002);
		rd(OFS_ACC_B_LOW, 16'hfffe, "msc_low");
		rd(OFS_ACC_A_HIGH, 16'hfffe, "negated_high");
		dsp(OP_ACC_ADD, 1'b0, 16'h0000, 16'h0000);
		rd(OFS_ACC_A_HIGH, 16'h0000, "acc_sum");
		dsp(OP_ACC_STORE, 1'b1, 16'h0000, 16'h0000);
		chk("xbus_data", 16'h0001, xbus_wdata_o);
		chk("xbus_we", 16'h0001, {15'h0000, xbus_we_o});
		load_word <= 16'h8000;
		dsp(OP_ACC_LOAD, 1'b0, 16'h0000, 16'h0000);
		chk("stored_word", 16'h0001, mem_word);
		rd(OFS_ACC_A_GUARD, 16'h00ff, "load_guard");
		wr(OFS_ACC_A_LOW, 16'h1234, 1'b0);
		wr(OFS_ACC_A_HIGH, 16'h5555, 1'b1);
		rd(OFS_ACC_A_LOW, 16'h1234, "slice_low");
		rd(OFS_ACC_A_HIGH, 16'h8000, "slice_high");
		rd(4'h9, 16'h0000, "unmapped");
		// single-operand multiply from the x bus, then an alu result sent to memory
		@(posedge clk_i);
		dsp_dual_i <= 1'b0;
		reg_direct_i <= 1'b0;
		load_word <= 16'h0003;
		dsp(OP_DSP_MPY, 1'b0, 16'h0007, 16'h0004);
		rd(OFS_ACC_A_LOW, 16'h000c, "xbus_operand");
		run_op(OP_XOR, 1'b0, 16'h00ff, 16'h0f0f);
		chk("alu_to_xbus", 16'h0ff0, xbus_wdata_o);
		chk("alu_xbus_we", 16'h0001, {15'h0000, xbus_we_o});
		wr(OFS_CORE_STATUS, 16'hffff, 1'b0);
		rd(OFS_CORE_STATUS, 16'h010f, "status_write");
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(OFS_CORE_CTRL, 16'h0000, "control_after_reset");
		chk("control_mirror", 16'h0000, core_control_register_o);
		chk("status_after_reset", STATUS_RST, core_status_register_o);
		end_sim;
	end
endmodule : tb_cpu_alu_dsp_datapath
